// [glc_field_decode.sv]
// Decodes the gain loop control fields into loop settings
`timescale 1ns/1ps
module glc_field_decode
    import glc_pkg::*;
(
    input  wire logic [1:0] hyst_sel,
    input  wire logic [1:0] wait_sel,
    input  wire logic [1:0] avg_sel,
    output logic      [3:0] hyst_amount,
    output logic      [3:0] dead_pos,
    output logic      [3:0] dead_neg,
    output logic      [2:0] loop_step,
    output logic      [5:0] wait_samples,
    output logic      [2:0] avg_shift,
    output logic      [4:0] ook_bound_db
);

    // ==========================================================
    // Hysteresis, dead zone and loop gain
    // ==========================================================
    always_comb begin
        unique case (hyst_sel)
            2'b00: begin
                hyst_amount = 4'h0;
                dead_pos    = 4'h2;
                dead_neg    = 4'h2;
                loop_step   = 3'h4;
            end
            2'b01: begin
                hyst_amount = 4'h1;
                dead_pos    = 4'h2;
                dead_neg    = 4'h3;
                loop_step   = 3'h2;
            end
            2'b10: begin
                hyst_amount = 4'h2;
                dead_pos    = 4'h4;
                dead_neg    = 4'h6;
                loop_step   = 3'h2;
            end
            2'b11: begin
                hyst_amount = 4'h4;
                dead_pos    = 4'h8;
                dead_neg    = 4'hc;
                loop_step   = 3'h1;
            end
        endcase
    end

    // ==========================================================
    // Wait length, averaging length and decision boundary
    // ==========================================================
    always_comb begin
        // Widen before adding so the top setting does not wrap to zero
        wait_samples = {3'(wait_sel) + 3'd1, 3'b000};
        avg_shift    = 3'd3 + {1'b0, avg_sel};
        ook_bound_db = {3'(avg_sel) + 3'd1, 2'b00};
    end

endmodule

// [glc_gain_loop.sv]
// Gain loop configuration register with APB access and loop sequencer
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module glc_gain_loop
    import glc_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              sample_valid,
    input  wire logic signed [7:0] mag_dev,
    input  wire logic              sync_found,
    input  wire logic              rx_restart,
    output logic                   gain_step_up,
    output logic                   gain_step_down,
    output logic                   step_digital,
    output logic      [2:0]        step_size,
    output logic      [4:0]        ook_bound_db
);

    // ==========================================================
    // Register and decoded settings
    // ==========================================================
    logic [7:0]       ctrl_reg;
    logic [7:0]       ctrl_next;
    logic [31:0]      prdata_reg;
    logic [31:0]      prdata_next;
    logic             pready_reg;
    logic             pready_next;
    logic             pslverr_reg;
    logic             pslverr_next;

    logic [1:0]       hyst_sel;
    logic [1:0]       wait_sel;
    logic [1:0]       hold_sel;
    logic [1:0]       avg_sel;
    logic [3:0]       hyst_amount;
    logic [3:0]       dead_pos;
    logic [3:0]       dead_neg;
    logic [2:0]       loop_step;
    logic [5:0]       wait_samples;
    logic [2:0]       avg_shift;
    logic [4:0]       ook_bound;

    assign hyst_sel = ctrl_reg[GLC_HYST_LSB +: 2];
    assign wait_sel = ctrl_reg[GLC_WAIT_LSB +: 2];
    assign hold_sel = ctrl_reg[GLC_HOLD_LSB +: 2];
    assign avg_sel  = ctrl_reg[GLC_AVG_LSB +: 2];

    glc_field_decode u_decode (
        .hyst_sel     (hyst_sel),
        .wait_sel     (wait_sel),
        .avg_sel      (avg_sel),
        .hyst_amount  (hyst_amount),
        .dead_pos     (dead_pos),
        .dead_neg     (dead_neg),
        .loop_step    (loop_step),
        .wait_samples (wait_samples),
        .avg_shift    (avg_shift),
        .ook_bound_db (ook_bound)
    );

    // ==========================================================
    // APB slave
    // ==========================================================
    logic             acc_phase;
    logic             is_ctrl;
    logic             is_status;
    logic [31:0]      status_word;

    assign acc_phase = psel & penable & pready_reg;
    assign is_ctrl   = (paddr == GLC_CTRL_ADDR);
    assign is_status = (paddr == GLC_STATUS_ADDR);

    always_comb begin
        ctrl_next    = ctrl_reg;
        prdata_next  = prdata_reg;
        pslverr_next = 1'b0;
        // No wait state: ready rises in the first access cycle
        pready_next  = psel & ~penable & ~pready_reg;
        if (psel & ~penable) begin
            if (!pwrite && is_ctrl) begin
                prdata_next = {24'h00_0000, ctrl_reg};
            end else if (!pwrite && is_status) begin
                prdata_next = status_word;
            end else begin
                prdata_next = 32'h0000_0000;
            end
            pslverr_next = ~(is_ctrl | (is_status & ~pwrite));
        end
        if (acc_phase && pwrite && is_ctrl && pstrb[0]) begin
            ctrl_next = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg    <= GLC_CTRL_RESET;
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            ctrl_reg    <= ctrl_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    // ==========================================================
    // Hold control
    // ==========================================================
    logic             lock_reg;
    logic             lock_next;
    logic             an_hold;
    logic             dig_hold;

    // A sync hit in the same cycle as a restart keeps the lock
    always_comb begin
        lock_next = lock_reg;
        if (rx_restart || hold_sel != GLC_HOLD_ON_SYNC) begin
            lock_next = 1'b0;
        end
        if (sync_found && hold_sel == GLC_HOLD_ON_SYNC) begin
            lock_next = 1'b1;
        end
    end

    always_comb begin
        unique case (hold_sel)
            GLC_HOLD_NONE: begin
                an_hold  = 1'b0;
                dig_hold = 1'b0;
            end
            GLC_HOLD_ON_SYNC: begin
                an_hold  = lock_reg;
                dig_hold = lock_reg;
            end
            GLC_HOLD_ANALOG: begin
                an_hold  = 1'b1;
                dig_hold = 1'b0;
            end
            GLC_HOLD_ALL: begin
                an_hold  = 1'b1;
                dig_hold = 1'b1;
            end
        endcase
    end

    // ==========================================================
    // Loop sequencer: wait, accumulate, decide
    // ==========================================================
    glc_state_e         state_reg;
    glc_state_e         state_next;
    logic [6:0]         cnt_reg;
    logic [6:0]         cnt_next;
    logic signed [14:0] sum_reg;
    logic signed [14:0] sum_next;
    logic [1:0]         last_dir_reg;
    logic [1:0]         last_dir_next;
    logic               up_reg;
    logic               up_next;
    logic               down_reg;
    logic               down_next;
    logic               dig_reg;
    logic               dig_next;
    logic [2:0]         size_reg;
    logic [2:0]         size_next;
    logic [4:0]         ook_reg;
    logic signed [14:0] avg;
    logic signed [14:0] thr_hi;
    logic signed [14:0] thr_lo;
    logic [6:0]         avg_len;

    assign avg_len = 7'd1 << avg_shift;
    assign avg     = sum_reg >>> avg_shift;

    // Reversing the previous step needs the extra hysteresis margin
    always_comb begin
        thr_hi = $signed({11'h000, dead_pos});
        thr_lo = -$signed({11'h000, dead_neg});
        if (last_dir_reg == 2'b01) begin
            thr_hi = thr_hi + $signed({11'h000, hyst_amount});
        end
        if (last_dir_reg == 2'b10) begin
            thr_lo = thr_lo - $signed({11'h000, hyst_amount});
        end
    end

    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        sum_next      = sum_reg;
        last_dir_next = last_dir_reg;
        up_next       = 1'b0;
        down_next     = 1'b0;
        dig_next      = dig_reg;
        size_next     = size_reg;
        unique case (state_reg)
            GLC_ST_WAIT: begin
                if (sample_valid) begin
                    cnt_next = cnt_reg + 7'd1;
                    if (cnt_next >= {1'b0, wait_samples}) begin
                        cnt_next   = 7'd0;
                        sum_next   = 15'sd0;
                        state_next = GLC_ST_ACCUM;
                    end
                end
            end
            GLC_ST_ACCUM: begin
                if (sample_valid) begin
                    sum_next = sum_reg + 15'(mag_dev);
                    cnt_next = cnt_reg + 7'd1;
                    if (cnt_next >= avg_len) begin
                        state_next = GLC_ST_DECIDE;
                    end
                end
            end
            GLC_ST_DECIDE: begin
                cnt_next   = 7'd0;
                sum_next   = 15'sd0;
                state_next = GLC_ST_ACCUM;
                if ((avg > thr_hi || avg < thr_lo) && !dig_hold) begin
                    up_next       = (avg < thr_lo);
                    down_next     = (avg > thr_hi);
                    last_dir_next = (avg > thr_hi) ? 2'b10 : 2'b01;
                    dig_next      = an_hold;
                    size_next     = loop_step;
                    state_next    = GLC_ST_WAIT;
                end
            end
            default: begin
                state_next = GLC_ST_WAIT;
            end
        endcase
        if (rx_restart) begin
            state_next    = GLC_ST_WAIT;
            cnt_next      = 7'd0;
            sum_next      = 15'sd0;
            last_dir_next = 2'b00;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg    <= GLC_ST_WAIT;
            cnt_reg      <= 7'd0;
            sum_reg      <= 15'sd0;
            last_dir_reg <= 2'b00;
            up_reg       <= 1'b0;
            down_reg     <= 1'b0;
            dig_reg      <= 1'b0;
            size_reg     <= 3'd0;
            ook_reg      <= 5'd0;
            lock_reg     <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            sum_reg      <= sum_next;
            last_dir_reg <= last_dir_next;
            up_reg       <= up_next;
            down_reg     <= down_next;
            dig_reg      <= dig_next;
            size_reg     <= size_next;
            ook_reg      <= ook_bound;
            lock_reg     <= lock_next;
        end
    end

    assign status_word = {27'h000_0000, dig_hold, an_hold, lock_reg,
                          state_reg};

    assign gain_step_up   = up_reg;
    assign gain_step_down = down_reg;
    assign step_digital   = dig_reg;
    assign step_size      = size_reg;
    assign ook_bound_db   = ook_reg;

endmodule

// [glc_gain_loop_chk.sv]
// Assertion checker for the gain loop configuration block
`timescale 1ns/1ps
module glc_gain_loop_chk
    import glc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        gain_step_up,
    input wire logic        gain_step_down,
    input wire logic        step_digital,
    input wire logic [2:0]  step_size,
    input wire logic [4:0]  ook_bound_db
);
    // ==========================================================
    // Mirror of the control register
    // ==========================================================
    logic [7:0] ctrl_reg;
    logic [3:0] quiet_reg;
    logic [2:0] exp_size;
    wire        commit = psel && penable && pready && pwrite
                         && paddr == GLC_CTRL_ADDR && pstrb[0];
    wire        step = gain_step_up || gain_step_down;

    // Quiet count keeps steps decided under an old setting out of checks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg  <= GLC_CTRL_RESET;
            quiet_reg <= 4'h0;
        end else begin
            if (commit) ctrl_reg <= pwdata[7:0];
            quiet_reg <= commit ? 4'h0 : quiet_reg + 4'(quiet_reg != 4'hf);
        end
    end

    always_comb begin
        case (ctrl_reg[7:6])
            2'h0: exp_size = 3'h4;
            2'h3: exp_size = 3'h1;
            default: exp_size = 3'h2;
        endcase
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ready_access; psel && !penable |=> pready; endproperty
    property p_ready_once; pready |=> !pready; endproperty
    property p_read_ctrl;
        pready && !pwrite && paddr == GLC_CTRL_ADDR
            |-> !pslverr && prdata == {24'h00_0000, ctrl_reg};
    endproperty
    property p_unmapped;
        pready && paddr != GLC_CTRL_ADDR && paddr != GLC_STATUS_ADDR
            |-> pslverr && prdata == 32'h0000_0000;
    endproperty
    property p_ook;
        commit |-> ##2 ook_bound_db == {3'(ctrl_reg[1:0]) + 3'h1, 2'b00};
    endproperty
    property p_pulse; step |=> !step; endproperty
    property p_size;
        step && quiet_reg > 4'h8 |-> step_size == exp_size;
    endproperty
    property p_hold_all;
        ctrl_reg[3:2] == GLC_HOLD_ALL && quiet_reg > 4'h8 |-> !step;
    endproperty
    property p_analog_hold;
        step && ctrl_reg[3:2] == GLC_HOLD_ANALOG && quiet_reg > 4'h8
            |-> step_digital;
    endproperty

    a_ready_access: assert property (p_ready_access)
        else $error("pready missing in access cycle");
    a_ready_once: assert property (p_ready_once)
        else $error("pready longer than one cycle");
    a_read_ctrl: assert property (p_read_ctrl)
        else $error("control readback differs");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");
    a_ook: assert property (p_ook)
        else $error("decision boundary wrong");
    a_pulse: assert property (p_pulse)
        else $error("step pulse too long");
    a_size: assert property (p_size)
        else $error("step size wrong");
    a_hold_all: assert property (p_hold_all)
        else $error("step while fully held");
    a_analog_hold: assert property (p_analog_hold)
        else $error("analogue step while held");

    cover property (gain_step_down);
    cover property (gain_step_up && step_digital);
    cover property (pready && pslverr);
endmodule

bind glc_gain_loop glc_gain_loop_chk u_chk (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .gain_step_up, .gain_step_down, .step_digital, .step_size, .ook_bound_db);

// [glc_pkg.sv]
// Shared constants for the receiver gain loop configuration block
package glc_pkg;

    // ==========================================================
    // Register map (printed offset is an index, byte = 4 * index)
    // ==========================================================
    localparam logic [7:0]  GLC_CTRL_INDEX   = 8'h1d;
    localparam logic [11:0] GLC_CTRL_ADDR    = {2'b00, GLC_CTRL_INDEX, 2'b00};
    localparam logic [11:0] GLC_STATUS_ADDR  = 12'h100;
    localparam logic [7:0]  GLC_CTRL_RESET   = 8'h91;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int GLC_HYST_LSB = 6;
    localparam int GLC_WAIT_LSB = 4;
    localparam int GLC_HOLD_LSB = 2;
    localparam int GLC_AVG_LSB  = 0;

    // ==========================================================
    // Gain hold settings
    // ==========================================================
    localparam logic [1:0] GLC_HOLD_NONE    = 2'h0;
    localparam logic [1:0] GLC_HOLD_ON_SYNC = 2'h1;
    localparam logic [1:0] GLC_HOLD_ANALOG  = 2'h2;
    localparam logic [1:0] GLC_HOLD_ALL     = 2'h3;

    // ==========================================================
    // Status register bit positions
    // ==========================================================
    localparam int GLC_ST_STATE_LSB = 0;
    localparam int GLC_ST_SYNC_LOCK = 2;
    localparam int GLC_ST_AN_HOLD   = 3;
    localparam int GLC_ST_DIG_HOLD  = 4;

    typedef enum logic [1:0] {
        GLC_ST_WAIT   = 2'b00,
        GLC_ST_ACCUM  = 2'b01,
        GLC_ST_DECIDE = 2'b10
    } glc_state_e;

endpackage

// [tb_receiver_gain_loop_config.sv]
// Self-checking testbench for the gain loop configuration block
`timescale 1ns/1ps
module tb_receiver_gain_loop_config import glc_pkg::*;;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic [3:0]  pstrb = 4'hf;
    logic        pready, pslverr, e, last_up, last_dig;
    logic        sample_valid = 1'b0, sync_found = 1'b0, rx_restart = 1'b0;
    logic [7:0]  mag_dev = 8'h00;
    logic        gain_step_up, gain_step_down, step_digital;
    logic [2:0]  step_size, last_size;
    logic [4:0]  ook_bound_db;
    logic [1:0]  f;
    int          error_cnt = 0, cmp_count = 0, steps = 0, n;

    always #12.5 pclk = ~pclk;

    glc_gain_loop dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .sample_valid,
        .mag_dev, .sync_found, .rx_restart, .gain_step_up, .gain_step_down,
        .step_digital, .step_size, .ook_bound_db);

    always @(posedge pclk) begin
        if (gain_step_up || gain_step_down) begin
            steps++;
            last_up = gain_step_up;
            last_dig = step_digital;
            last_size = step_size;
        end
    end

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic cfg(input logic [7:0] v);
        apb(1'b1, GLC_CTRL_ADDR, {24'h00_0000, v});
    endtask

    // Sparse samples let each step pulse land before the next sample
    task automatic feed(input logic [7:0] dev, input int lim);
        int s0;
        s0 = steps;
        n = 0;
        while (steps == s0 && n < lim) begin
            sample_valid <= 1'b1;
            mag_dev <= dev;
            @(posedge pclk);
            sample_valid <= 1'b0;
            repeat (4) @(posedge pclk);
            n++;
        end
    endtask

    task automatic finish_test;
        if (error_cnt == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, GLC_CTRL_ADDR, 32'h0000_0000);
        chk(q, 32'h0000_0091);
        chk(32'(ook_bound_db), 32'h0000_0008);
        apb(1'b0, 12'h200, 32'h0000_0000);
        chk({q[30:0], e}, 32'h0000_0001);
        pstrb <= 4'h0;
        cfg(8'hff);
        pstrb <= 4'hf;
        apb(1'b0, GLC_CTRL_ADDR, 32'h0000_0000);
        chk(q, 32'h0000_0091);
        for (int i = 0; i < 4; i++) begin
            f = 2'(i);
            cfg({f, f, 2'b00, f});
            apb(1'b0, GLC_CTRL_ADDR, 32'h0000_0000);
            chk(q, {24'h00_0000, f, f, 2'b00, f});
            chk(32'(ook_bound_db), 32'(4 * (i + 1)));
            feed(8'h14, 300);
            feed(8'h14, 300);
            chk(32'(n), 32'(8 * (i + 1) + (8 << i)));
            chk(32'(last_size), (i == 0) ? 4 : (i == 3) ? 1 : 2);
            chk({last_up, last_dig}, 32'h0000_0000);
        end
        cfg(8'h00);
        feed(8'h01, 60);
        chk(32'(n), 32'h0000_003c);
        feed(8'hec, 300);
        chk({n < 300, last_up}, 32'h0000_0003);
        cfg(8'h08);
        feed(8'h14, 300);
        feed(8'h14, 300);
        chk({last_dig, 8'(n)}, 32'h0000_0110);
        cfg(8'h0c);
        feed(8'h14, 100);
        chk(32'(n), 32'h0000_0064);
        cfg(8'h04);
        feed(8'h14, 300);
        chk(32'(n < 300), 32'h0000_0001);
        sync_found <= 1'b1;
        @(posedge pclk);
        sync_found <= 1'b0;
        feed(8'h14, 60);
        chk(32'(n), 32'h0000_003c);
        apb(1'b0, GLC_STATUS_ADDR, 32'h0000_0000);
        chk(q, 32'h0000_001d);
        apb(1'b1, GLC_STATUS_ADDR, 32'h0000_0000);
        chk(32'(e), 32'h0000_0001);
        rx_restart <= 1'b1;
        @(posedge pclk);
        rx_restart <= 1'b0;
        feed(8'h14, 300);
        chk(32'(n < 300), 32'h0000_0001);
        finish_test;
    end

    initial begin
        #2_000_000;
        error_cnt++;
        finish_test;
    end
endmodule
